//--- verif/chan_model.sv
// host channel model answering service in with service out or command out
// assumes one clock shared with the packer; the answer delay is set by the bench
`timescale 1ns/10ps
module chan_model (
  input  wire logic       core_clk,
  input  wire logic       rst_b,
  input  wire logic       service_in,
  input  wire logic [7:0] bus_in,
  input  wire logic       refuse,
  input  wire logic       sel_pulse,
  input  wire logic [3:0] delay,
  output logic            service_out,
  output logic            command_out,
  output logic [7:0]      last_byte,
  output int              n_bytes
);
  logic [3:0] wait_q;
  logic [3:0] sel_cnt;
  always @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      service_out <= 1'b0;
      command_out <= 1'b0;
      wait_q      <= 4'h0;
      sel_cnt     <= 4'h0;
      last_byte   <= 8'h00;
      n_bytes     <= 0;
    end else if (sel_pulse && !service_in) begin
      service_out <= 1'b1;
      sel_cnt     <= 4'h6;
    end else if (sel_cnt != 4'h0) begin
      sel_cnt <= sel_cnt - 4'h1;
      if (sel_cnt == 4'h1)
        service_out <= 1'b0;
    end else if (service_in && !service_out && !command_out) begin
      // slow answers only stretch the request; the byte is taken when accepted
      if (wait_q < delay)
        wait_q <= wait_q + 4'h1;
      else begin
        wait_q <= 4'h0;
        if (refuse)
          command_out <= 1'b1;
        else begin
          service_out <= 1'b1;
          last_byte   <= bus_in;
          n_bytes     <= n_bytes + 1;
        end
      end
    end else if (!service_in) begin
      service_out <= 1'b0;
      command_out <= 1'b0;
    end
  end
endmodule : chan_model

//--- verif/read_six_to_eight_packer_tb.sv
// self-checking bench for the six-to-eight read packer
// assumes the channel model above and one 50 MHz clock
`timescale 1ns/10ps
module read_six_to_eight_packer_tb;
  logic core_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_address = 4'h0, delay = 4'h0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic avs_waitrequest, irq, service_in, service_out, command_out, convert_pad_flag, si_d;
  logic char_start = 1'b0, block_end_timing = 1'b0, status_phase = 1'b0, refuse = 1'b0, sel_pulse = 1'b0;
  logic [5:0] char_data = 6'h00;
  logic [7:0] bus_in, last_byte;
  logic [31:0] rd;
  int n_bytes, n_req = 0, n_errors = 0, tests_run = 0;
  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    si_d <= service_in;
    if (service_in === 1'b1 && si_d === 1'b0)
      n_req <= n_req + 1;
  end
  read_six_to_eight_packer i_read_six_to_eight_packer (.core_clk(core_clk), .rst_b(rst_b),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq), .char_start(char_start),
    .char_data(char_data), .block_end_timing(block_end_timing), .status_phase(status_phase),
    .service_out(service_out), .command_out(command_out), .service_in(service_in), .bus_in(bus_in),
    .convert_pad_flag(convert_pad_flag));
  chan_model i_chan_model (.core_clk(core_clk), .rst_b(rst_b), .service_in(service_in), .bus_in(bus_in),
    .refuse(refuse), .sel_pulse(sel_pulse), .delay(delay), .service_out(service_out),
    .command_out(command_out), .last_byte(last_byte), .n_bytes(n_bytes));
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // request held from one rising edge to the edge where waitrequest is low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    int k;
    avs_address <= a;
    avs_writedata <= d;
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    if (k == 40) begin n_errors++; close_out(); end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  // settle: let the handshake finish, then the 3-cycle synchronised clear
  task automatic settle();
    int k;
    for (k = 0; k < 80; k++) begin
      @(negedge core_clk);
      if ((service_in | service_out | command_out) === 1'b0) break;
    end
    if (k == 80) begin n_errors++; close_out(); end
    repeat (6) @(posedge core_clk);
  endtask : settle
  task automatic send_char(input logic [5:0] c);
    char_data <= c;
    char_start <= 1'b1;
    @(posedge core_clk);
    char_start <= 1'b0;
    repeat (12) @(posedge core_clk);
    settle();
  endtask : send_char
  task automatic block_end();
    block_end_timing <= 1'b1;
    @(posedge core_clk);
    block_end_timing <= 1'b0;
    repeat (3) @(posedge core_clk);
    settle();
  endtask : block_end
  task automatic init_sel();
    status_phase <= 1'b1;
    sel_pulse <= 1'b1;
    @(posedge core_clk);
    sel_pulse <= 1'b0;
    repeat (12) @(posedge core_clk);
    status_phase <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask : init_sel
  task automatic t_regs();
    bus(1'b0, rd_pack_pkg::OFF_CTRL, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    bus(1'b0, rd_pack_pkg::OFF_MASK, 32'h0);
    chk("mask reset", 32'h0, rd);
    bus(1'b1, rd_pack_pkg::OFF_CTRL, 32'h1);
    bus(1'b1, rd_pack_pkg::OFF_MASK, 32'h2);
    bus(1'b0, rd_pack_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h1, rd);
    $display("test regs done");
  endtask : t_regs
  task automatic t_group();
    logic [5:0] c [4] = '{6'h2d, 6'h33, 6'h1e, 6'h27};
    init_sel();
    delay <= 4'h0;
    send_char(c[0]);
    chk("bytes after first char", 32'd0, n_bytes);
    send_char(c[1]);
    chk("byte one", {c[0], c[1][5:4]}, last_byte);
    delay <= 4'h7;
    send_char(c[2]);
    chk("byte two", {c[2][5:2], c[1][3:0]}, last_byte);
    send_char(c[3]);
    chk("byte three", {c[2][1:0], c[3]}, last_byte);
    chk("bytes per group", 32'd3, n_bytes);
    chk("requests", 32'd3, n_req);
    bus(1'b0, rd_pack_pkg::OFF_STATUS, 32'h0);
    chk("status byte", 32'h1, rd & 32'h1);
    $display("test group done");
  endtask : t_group
  task automatic t_pad();
    send_char(6'h15);
    chk("no byte on lone char", 32'd3, n_bytes);
    block_end();
    chk("pad byte", {6'h15, 2'b00}, last_byte);
    chk("pad flag", 32'h1, convert_pad_flag);
    chk("irq pad", 32'h1, irq);
    bus(1'b0, rd_pack_pkg::OFF_STATUS, 32'h0);
    chk("status pad", 32'h2, rd & 32'h2);
    chk("irq cleared", 32'h0, irq);
    chk("pad flag held", 32'h1, convert_pad_flag);
    $display("test pad done");
  endtask : t_pad
  task automatic t_two_blank();
    init_sel();
    chk("pad flag cleared", 32'h0, convert_pad_flag);
    send_char(6'h3f);
    send_char(6'h20);
    chk("two left byte", {6'h3f, 2'b10}, last_byte);
    block_end();
    chk("no pad byte", 32'd5, n_bytes);
    chk("no pad flag", 32'h0, convert_pad_flag);
    $display("test two blank done");
  endtask : t_two_blank
  task automatic t_stop();
    int r0;
    init_sel();
    send_char(6'h01);
    refuse <= 1'b1;
    send_char(6'h02);
    r0 = n_req;
    send_char(6'h03);
    send_char(6'h04);
    chk("requests after stop", r0, n_req);
    chk("bytes after stop", 32'd5, n_bytes);
    bus(1'b0, rd_pack_pkg::OFF_STATUS, 32'h0);
    chk("status stop", 32'h4, rd & 32'h4);
    refuse <= 1'b0;
    $display("test stop done");
  endtask : t_stop
  task automatic t_three();
    init_sel();
    send_char(6'h01);
    send_char(6'h02);
    send_char(6'h03);
    chk("bytes before pad", 32'd7, n_bytes);
    block_end();
    chk("three left pad byte", 32'hc0, last_byte);
    chk("three left flag", 32'h1, convert_pad_flag);
    chk("bytes after pad", 32'd8, n_bytes);
    $display("test three left done");
  endtask : t_three
  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
    t_regs();
    t_group();
    t_pad();
    t_two_blank();
    t_stop();
    t_three();
    close_out();
  end
endmodule : read_six_to_eight_packer_tb

//--- verilog/rd_pack_pkg.sv
// shared constants and types for the six-to-eight read packer
// assumes a single 50 MHz core clock domain
package rd_pack_pkg;
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CHAR_BITS    = 6;
  localparam int unsigned BYTE_BITS    = 8;
  localparam int unsigned DREG_BITS    = 12;
  // read clock phases, one core cycle each
  localparam logic [3:0]  RC_STEP      = 4'h2;
  localparam logic [3:0]  RC_LOAD      = 4'h8;
  localparam logic [3:0]  RC_LAST      = 4'h9;
  // register byte offsets
  localparam logic [3:0]  OFF_CTRL     = 4'h0;
  localparam logic [3:0]  OFF_STATUS   = 4'h4;
  localparam logic [3:0]  OFF_MASK     = 4'h8;
  localparam logic [3:0]  OFF_STATE    = 4'hc;
  // status and mask bit positions
  localparam int unsigned EV_BYTE      = 0;
  localparam int unsigned EV_PAD       = 1;
  localparam int unsigned EV_STOP      = 2;
  localparam int unsigned EV_BITS      = 3;
  localparam logic [0:0]  CTRL_RESET   = 1'h0;
  localparam logic [2:0]  MASK_RESET   = 3'h0;
  // register clear masks, position 1 in bit 11
  localparam logic [11:0] CLR_LOW      = 12'hfc0;
  localparam logic [11:0] CLR_HIGH     = 12'h03f;
  localparam logic [11:0] CLR_ALL      = 12'hfff;

  typedef enum logic [1:0] {
    BC_ZERO,
    BC_ONE,
    BC_TWO,
    BC_THREE
  } byte_count_t;

  typedef enum {
    HS_IDLE,
    HS_REQ,
    HS_FALL
  } hs_state_t;

  typedef struct packed {
    logic        pad_pending;
    logic        pad_flag;
    logic        stop;
    logic        first_third;
    byte_count_t bc;
  } conv_state_t;
endpackage : rd_pack_pkg

//--- verilog/read_six_to_eight_packer.sv
// read-direction six-to-eight packer with channel tag handshake and Avalon-MM registers
// assumes char_start/char_data/block_end come from same-clock tape logic;
// service_out and command_out are channel pins and are synchronised here
`timescale 1ns/10ps
module read_six_to_eight_packer #(
  parameter int unsigned ADDR_W = 4
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic [ADDR_W-1:0] avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  output logic      [31:0]       avs_readdata,
  output logic                   avs_waitrequest,
  output logic                   irq,
  input  wire logic              char_start,
  input  wire logic [5:0]        char_data,
  input  wire logic              block_end_timing,
  input  wire logic              status_phase,
  input  wire logic              service_out,
  input  wire logic              command_out,
  output logic                   service_in,
  output logic      [7:0]        bus_in,
  output logic                   convert_pad_flag
);

  function automatic logic [7:0] sel_byte(input rd_pack_pkg::byte_count_t bc, input logic [11:0] r);
    case (bc)
      rd_pack_pkg::BC_ONE:   sel_byte = r[11:4];
      rd_pack_pkg::BC_TWO:   sel_byte = {r[11:8], r[3:0]};
      rd_pack_pkg::BC_THREE: sel_byte = r[7:0];
      default:               sel_byte = 8'h00;
    endcase
  endfunction : sel_byte

  // channel tag synchronisers
  logic        so_s1_q, so_s2_q, so_s3_q;
  logic        co_s1_q, co_s2_q, co_s3_q;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      so_s1_q <= 1'b0;
      so_s2_q <= 1'b0;
      so_s3_q <= 1'b0;
      co_s1_q <= 1'b0;
      co_s2_q <= 1'b0;
      co_s3_q <= 1'b0;
    end else begin
      so_s1_q <= service_out;
      so_s2_q <= so_s1_q;
      so_s3_q <= so_s2_q;
      co_s1_q <= command_out;
      co_s2_q <= co_s1_q;
      co_s3_q <= co_s2_q;
    end
  end
  wire so_rise = so_s2_q & ~so_s3_q;
  wire so_fall = ~so_s2_q & so_s3_q;
  wire co_rise = co_s2_q & ~co_s3_q;

  // registers
  logic [0:0]  ctrl_q;
  logic [2:0]  status_q, status_d;
  logic [2:0]  mask_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  wire convert_en = ctrl_q[0];
  wire req        = avs_read | avs_write;
  wire take       = req & ~ack_q;
  wire done       = req & ack_q;
  wire [3:0] off  = {avs_address[3:2], 2'b00};

  // read clock
  logic        rc_run_q;
  logic [3:0]  rc_phase_q;
  wire rc_step   = rc_run_q & (rc_phase_q == rd_pack_pkg::RC_STEP);
  wire rc_load   = rc_run_q & (rc_phase_q == rd_pack_pkg::RC_LOAD);
  wire rc_strobe = rc_run_q & (rc_phase_q == rd_pack_pkg::RC_LAST);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rc_run_q   <= 1'b0;
      rc_phase_q <= 4'h0;
    end else if (rc_strobe) begin
      rc_run_q   <= 1'b0;
      rc_phase_q <= 4'h0;
    end else if (rc_run_q) begin
      rc_phase_q <= rc_phase_q + 4'h1;
    end else if (char_start && convert_en) begin
      rc_run_q   <= 1'b1;
    end
  end

  // conversion state
  rd_pack_pkg::conv_state_t st_q, st_d;
  rd_pack_pkg::hs_state_t   hs_q, hs_d;
  logic [11:0] dreg_q, dreg_d;
  logic [7:0]  bus_in_q, bus_in_d;

  wire init_ev   = so_rise & status_phase & (hs_q == rd_pack_pkg::HS_IDLE);
  wire inhibit   = (st_q.bc == rd_pack_pkg::BC_ONE) & st_q.first_third;
  // full byte waits at strobe time; counter already stepped at RC_STEP, seven core cycles earlier
  wire byte_rdy  = (st_q.bc != rd_pack_pkg::BC_ZERO) & ~inhibit & ~st_q.stop;
  wire norm_req  = rc_strobe & byte_rdy & (hs_q == rd_pack_pkg::HS_IDLE);
  wire left_one  = (st_q.bc == rd_pack_pkg::BC_ONE) & st_q.first_third;
  wire left_two  = (st_q.bc == rd_pack_pkg::BC_TWO) & ~st_q.first_third & (dreg_q[3:0] != 4'h0);
  wire left_thr  = (st_q.bc == rd_pack_pkg::BC_THREE) & st_q.first_third & (dreg_q[7:6] != 2'h0);
  wire pad_req   = block_end_timing & convert_en & ~st_q.stop & (hs_q == rd_pack_pkg::HS_IDLE)
                   & (left_one | left_two | left_thr);
  wire [7:0] pad_byte = left_one ? {dreg_q[11:6], 2'b00} :
                        left_two ? {4'h0, dreg_q[3:0]} :
                                   {dreg_q[7:6], 6'h00};
  wire accept    = so_rise & (hs_q == rd_pack_pkg::HS_REQ);
  wire refuse    = co_rise & (hs_q == rd_pack_pkg::HS_REQ) & ~so_rise;
  wire [11:0] fall_mask = (st_q.bc == rd_pack_pkg::BC_TWO)   ? rd_pack_pkg::CLR_LOW :
                          (st_q.bc == rd_pack_pkg::BC_THREE) ? rd_pack_pkg::CLR_HIGH :
                                                               rd_pack_pkg::CLR_ALL;
  wire do_fall   = so_fall & (hs_q == rd_pack_pkg::HS_FALL);

  always_comb begin
    st_d     = st_q;
    hs_d     = hs_q;
    bus_in_d = bus_in_q;
    dreg_d   = dreg_q;
    if (init_ev) begin
      st_d.bc          = rd_pack_pkg::BC_ONE;
      st_d.first_third = 1'b0;
      st_d.stop        = 1'b0;
      st_d.pad_flag    = 1'b0;
      st_d.pad_pending = 1'b0;
      dreg_d           = 12'h000;
    end else begin
      if (do_fall) begin
        dreg_d = dreg_q & ~fall_mask;
        hs_d   = rd_pack_pkg::HS_IDLE;
      end
      if (rc_load) begin
        if (st_q.first_third) begin
          dreg_d[11:6] = char_data;
        end else begin
          dreg_d[5:0] = char_data;
        end
      end
      if (accept) begin
        hs_d = rd_pack_pkg::HS_FALL;
        if (st_q.pad_pending) begin
          st_d.bc          = rd_pack_pkg::BC_ZERO;
          st_d.pad_pending = 1'b0;
        end else begin
          st_d.bc = rd_pack_pkg::byte_count_t'(st_q.bc + 2'h1);
        end
      end else if (refuse) begin
        st_d.stop        = 1'b1;
        st_d.pad_pending = 1'b0;
        hs_d             = rd_pack_pkg::HS_IDLE;
      end else if (rc_step) begin
        st_d.first_third = ~st_q.first_third;
        if (st_q.bc == rd_pack_pkg::BC_ZERO) begin
          st_d.bc = rd_pack_pkg::BC_ONE;
        end
      end else if (pad_req) begin
        hs_d             = rd_pack_pkg::HS_REQ;
        bus_in_d         = pad_byte;
        st_d.pad_flag    = 1'b1;
        st_d.pad_pending = 1'b1;
      end else if (norm_req) begin
        hs_d     = rd_pack_pkg::HS_REQ;
        bus_in_d = sel_byte(st_q.bc, dreg_q);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q     <= '0;
      hs_q     <= rd_pack_pkg::HS_IDLE;
      dreg_q   <= 12'h000;
      bus_in_q <= 8'h00;
    end else begin
      st_q     <= st_d;
      hs_q     <= hs_d;
      dreg_q   <= dreg_d;
      bus_in_q <= bus_in_d;
    end
  end

  // request drops three core cycles after the channel answers, once the synchronised edge is seen
  assign service_in       = (hs_q == rd_pack_pkg::HS_REQ);
  assign bus_in           = bus_in_q;
  assign convert_pad_flag = st_q.pad_flag;

  // events and register file
  logic [2:0] ev;
  always_comb begin
    ev                      = 3'h0;
    ev[rd_pack_pkg::EV_BYTE] = accept;
    ev[rd_pack_pkg::EV_PAD]  = pad_req & ~init_ev & ~accept & ~refuse & ~rc_step;
    ev[rd_pack_pkg::EV_STOP] = refuse & ~init_ev;
  end
  wire status_rd = done & avs_read & (off == rd_pack_pkg::OFF_STATUS);
  // set wins over the read clear
  always_comb begin
    status_d = status_q;
    if (status_rd) begin
      // rdata was captured a cycle earlier; an event landing since then must survive
      status_d = status_q & ~rdata_q[2:0];
    end
    status_d = status_d | ev;
  end

  wire [31:0] rd_mux = (off == rd_pack_pkg::OFF_CTRL)   ? {31'h0, ctrl_q} :
                       (off == rd_pack_pkg::OFF_STATUS) ? {29'h0, status_q} :
                       (off == rd_pack_pkg::OFF_MASK)   ? {29'h0, mask_q} :
                       {26'h0, st_q.pad_pending, st_q.pad_flag, st_q.stop, st_q.first_third, st_q.bc};

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q   <= rd_pack_pkg::CTRL_RESET;
      mask_q   <= rd_pack_pkg::MASK_RESET;
      status_q <= 3'h0;
      ack_q    <= 1'b0;
      rdata_q  <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
      ack_q    <= take;
      if (take && avs_read) begin
        rdata_q <= rd_mux;
      end
      if (done && avs_write && off == rd_pack_pkg::OFF_CTRL) begin
        ctrl_q <= avs_writedata[0:0];
      end
      if (done && avs_write && off == rd_pack_pkg::OFF_MASK) begin
        mask_q <= avs_writedata[2:0];
      end
    end
  end
  assign avs_waitrequest = req & ~ack_q;
  assign avs_readdata    = rdata_q;
  assign irq             = |(status_q & mask_q);

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  sequence s_accept_normal;
    accept && !st_q.pad_pending && !init_ev;
  endsequence

  // a fall that no load or preset overlaps
  sequence s_fall_clean;
    do_fall && !rc_load && !init_ev;
  endsequence

  // a counter step that no handshake event overrides
  sequence s_step_clean;
    rc_step && !accept && !refuse && !init_ev;
  endsequence

  // a pad request that wins its cycle
  sequence s_pad_clean;
    pad_req && !init_ev && !accept && !refuse && !rc_step;
  endsequence

  a_load_odd: assert property (rc_load && st_q.first_third && !init_ev |=> dreg_q[11:6] == $past(char_data))
    else $error("odd character not in positions 1-6");

  a_load_even: assert property (rc_load && !st_q.first_third && !init_ev |=> dreg_q[5:0] == $past(char_data))
    else $error("even character not in positions 7-12");

  a_fall_high: assert property (s_fall_clean ##0 (st_q.bc == rd_pack_pkg::BC_THREE) |=> dreg_q[5:0] == 6'h00)
    else $error("positions 7-12 not cleared");

  a_fall_all: assert property (s_fall_clean ##0 (st_q.bc == rd_pack_pkg::BC_ZERO) |=> dreg_q == 12'h000)
    else $error("register not cleared after third byte");

  a_wrap_step: assert property (s_step_clean ##0 (st_q.bc == rd_pack_pkg::BC_ZERO) |=> st_q.bc == rd_pack_pkg::BC_ONE)
    else $error("byte counter did not wrap to one");

  a_pad_three: assert property (s_pad_clean ##0 left_thr
                                |=> service_in && convert_pad_flag && bus_in == {$past(dreg_q[7:6]), 6'h00})
    else $error("three-character pad byte wrong");

  a_pad_two: assert property (s_pad_clean ##0 left_two
                              |=> service_in && convert_pad_flag && bus_in == {4'h0, $past(dreg_q[3:0])})
    else $error("two-character pad byte wrong");

  a_pad_close: assert property (accept && st_q.pad_pending && !init_ev |=> st_q.bc == rd_pack_pkg::BC_ZERO)
    else $error("byte count not closed after pad byte");

  a_stop_set: assert property (refuse && !init_ev |=> st_q.stop)
    else $error("stop trigger not set by command out");

  a_flag_hold: assert property (convert_pad_flag && !init_ev |=> convert_pad_flag)
    else $error("pad flag dropped before next operation");

  a_req_source: assert property ($rose(service_in) |-> $past(rc_strobe) || $past(pad_req))
    else $error("service in raised outside strobe or pad");

  a_req_hold: assert property (service_in && !accept && !refuse |=> service_in)
    else $error("service in dropped before an answer");

  a_convert_off: assert property (!convert_en && !rc_run_q |=> !rc_run_q)
    else $error("read clock ran with conversion off");

  a_init_state: assert property (init_ev |=> !st_q.stop && !st_q.first_third && !service_in)
    else $error("initial selection left stale state");

  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");

  a_inhibit_first: assert property ($rose(service_in) && !st_q.pad_pending |-> !(st_q.bc == rd_pack_pkg::BC_ONE && st_q.first_third))
    else $error("service in raised while first byte inhibited");
  a_stop_blocks: assert property (st_q.stop && !init_ev |=> !$rose(service_in))
    else $error("service in raised after stop");
  a_step_toggle: assert property (rc_step && !accept && !refuse && !init_ev |=> st_q.first_third != $past(st_q.first_third))
    else $error("character counter did not step");
  a_bus_select: assert property ($rose(service_in) && !st_q.pad_pending |-> bus_in == sel_byte(st_q.bc, dreg_q))
    else $error("wrong byte gated to bus in");
  a_count_adv: assert property (s_accept_normal |=> st_q.bc == rd_pack_pkg::byte_count_t'($past(st_q.bc) + 2'h1))
    else $error("byte counter did not advance");
  a_init_clear: assert property (init_ev |=> st_q.bc == rd_pack_pkg::BC_ONE && dreg_q == 12'h000 && !convert_pad_flag)
    else $error("initial service out did not preset");
  a_fall_low: assert property (do_fall && st_q.bc == rd_pack_pkg::BC_TWO && !rc_load && !init_ev |=> dreg_q[11:6] == 6'h00)
    else $error("positions 1-6 not cleared");
  a_rc_length: assert property ($rose(rc_run_q) |-> rc_run_q [*8] ##1 rc_run_q [*2] ##1 !rc_run_q)
    else $error("read clock cycle length wrong");
  a_pad_one: assert property (pad_req && left_one && !init_ev && !accept && !refuse && !rc_step
                              |=> service_in && convert_pad_flag && bus_in == {$past(dreg_q[11:6]), 2'b00})
    else $error("one-character pad byte wrong");
  a_pad_two_blank: assert property (block_end_timing && st_q.bc == rd_pack_pkg::BC_TWO && !st_q.first_third
                                    && dreg_q[3:0] == 4'h0 && !service_in |=> !$rose(service_in))
    else $error("pad requested with blank positions 9-12");
endmodule : read_six_to_eight_packer
